/* File: design/digital_out_port_with_interlock.sv */
// Four-bit digital output port with fixture interlock gating the main output
// Summary of operation
// - Four output lines are each driven high or low from the port setting.
// - Port value 0 to 15 maps bit 0 to line one through bit 3 to line four.
// - Each line is driven exactly to the commanded level; the load wiring picks the active level.
// - A configuration bit turns the interlock on or off; off means the interlock line is ignored.
// - With interlock on, an output-on request is refused unless the interlock input is low.
// - With interlock on, the main output is forced off on the third enabled clock edge after the interlock input goes high.
// - After a trip, only a fresh on request made with the interlock low restores the output.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module digital_out_port_with_interlock #(
	parameter int PORT_WIDTH = dio_pkg::PORT_WIDTH
) (
	input  wire logic                             clk_sys,
	input  wire logic                             rst,
	input  wire logic                             clkEn,
	input  wire logic [dio_pkg::ADDR_WIDTH-1:0]   regAddr,
	input  wire logic [dio_pkg::DATA_WIDTH-1:0]   regWriteData,
	input  wire logic                             regWrite,
	input  wire logic                             regRead,
	output logic      [dio_pkg::DATA_WIDTH-1:0]   regReadData,
	input  wire logic                             outputOnKey,
	input  wire logic                             outputOffKey,
	input  wire logic                             interlockIn,
	output logic      [PORT_WIDTH-1:0]            portLines,
	output logic                                  mainOutputOn,
	output logic                                  interlockTripped
);
	// Reset value and read path are sized by the package width
	if (PORT_WIDTH != dio_pkg::PORT_WIDTH) begin : g_width_check
		$error("PORT_WIDTH must equal the package port width");
	end

	dio_pkg::reg_req_s    req;
	dio_pkg::output_req_s outReq;
	logic                 interlockSync;
	logic                 interlockEnable;
	logic                 interlockOpen;
	logic                 writePort;
	logic                 writeControl;
	logic                 next_mainOutputOn;
	logic [dio_pkg::DATA_WIDTH-1:0] next_readData;

	assign req.writeStrobe = regWrite;
	assign req.readStrobe  = regRead;
	assign req.address     = regAddr;
	assign req.writeData   = regWriteData;

	assign writePort    = req.writeStrobe && req.address == dio_pkg::PORT_VALUE_ADDR;
	assign writeControl = req.writeStrobe && req.address == dio_pkg::CONTROL_ADDR;

	// On and off requests come from the front panel keys or the control register
	assign outReq.onRequest  = outputOnKey ||
		(writeControl && req.writeData[dio_pkg::CTRL_OUTPUT_ON_BIT]);
	assign outReq.offRequest = outputOffKey ||
		(writeControl && req.writeData[dio_pkg::CTRL_OUTPUT_OFF_BIT]);

	interlock_sync #(
		.RESET_LEVEL (1'b1)
	) u_interlock_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clkEn   (clkEn),
		.asyncIn (interlockIn),
		.syncOut (interlockSync)
	);

	// High means the fixture lid is open
	assign interlockOpen = interlockEnable && interlockSync;

	// Port value setting
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			portLines <= dio_pkg::PORT_VALUE_RESET;
		end else if (clkEn && writePort) begin
			portLines <= req.writeData[PORT_WIDTH-1:0];
		end
	end

	// Interlock configuration
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			interlockEnable <= dio_pkg::INTERLOCK_EN_RESET;
		end else if (clkEn && writeControl) begin
			interlockEnable <= req.writeData[dio_pkg::CTRL_INTERLOCK_EN_BIT];
		end
	end

	// Main output gating
	always_comb begin
		next_mainOutputOn = mainOutputOn;
		if (outReq.offRequest) begin
			next_mainOutputOn = 1'b0;
		end else if (outReq.onRequest && !interlockOpen) begin
			next_mainOutputOn = 1'b1;
		end
		if (interlockOpen) begin
			next_mainOutputOn = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mainOutputOn <= 1'b0;
		end else if (clkEn) begin
			mainOutputOn <= next_mainOutputOn;
		end
	end

	// Trip flag: set on forced off, cleared only by a successful on request
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			interlockTripped <= 1'b0;
		end else if (clkEn) begin
			if (interlockOpen && mainOutputOn) begin
				interlockTripped <= 1'b1;
			end else if (next_mainOutputOn) begin
				interlockTripped <= 1'b0;
			end
		end
	end

	// Register read path, data valid the cycle after the strobe
	always_comb begin
		next_readData = '0;
		unique case (req.address)
			dio_pkg::PORT_VALUE_ADDR: begin
				next_readData[PORT_WIDTH-1:0] = portLines;
			end
			dio_pkg::CONTROL_ADDR: begin
				next_readData[dio_pkg::CTRL_INTERLOCK_EN_BIT] = interlockEnable;
			end
			dio_pkg::STATUS_ADDR: begin
				next_readData[dio_pkg::STAT_MAIN_OUTPUT_BIT]  = mainOutputOn;
				next_readData[dio_pkg::STAT_INTERLOCK_BIT]    = interlockSync;
				next_readData[dio_pkg::STAT_TRIPPED_BIT]      = interlockTripped;
				next_readData[dio_pkg::STAT_INTERLOCK_EN_BIT] = interlockEnable;
			end
			default: begin
				next_readData = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regReadData <= '0;
		end else if (clkEn) begin
			regReadData <= req.readStrobe ? next_readData : '0;
		end
	end
endmodule : digital_out_port_with_interlock

/* File: design/dio_pkg.sv */
// Package: register map, field layout and carrier types of the digital output port
package dio_pkg;
	localparam int PORT_WIDTH = 4;
	localparam int ADDR_WIDTH = 4;
	localparam int DATA_WIDTH = 32;

	localparam logic [ADDR_WIDTH-1:0] PORT_VALUE_ADDR = 4'h0;
	localparam logic [ADDR_WIDTH-1:0] CONTROL_ADDR    = 4'h4;
	localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR     = 4'h8;

	localparam int CTRL_INTERLOCK_EN_BIT = 0;
	localparam int CTRL_OUTPUT_ON_BIT    = 1;
	localparam int CTRL_OUTPUT_OFF_BIT   = 2;

	localparam int STAT_MAIN_OUTPUT_BIT = 0;
	localparam int STAT_INTERLOCK_BIT   = 1;
	localparam int STAT_TRIPPED_BIT     = 2;
	localparam int STAT_INTERLOCK_EN_BIT = 3;

	localparam logic [PORT_WIDTH-1:0] PORT_VALUE_RESET = 4'h0;
	localparam logic                  INTERLOCK_EN_RESET = 1'b0;

	typedef struct packed {
		logic                  writeStrobe;
		logic                  readStrobe;
		logic [ADDR_WIDTH-1:0] address;
		logic [DATA_WIDTH-1:0] writeData;
	} reg_req_s;

	typedef struct packed {
		logic onRequest;
		logic offRequest;
	} output_req_s;
endpackage : dio_pkg

/* File: design/interlock_sync.sv */
// Two-stage synchroniser for the fixture interlock input
`timescale 1ns/1ps
module interlock_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic clkEn,
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic firstStage;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			firstStage <= RESET_LEVEL;
			syncOut    <= RESET_LEVEL;
		end else if (clkEn) begin
			firstStage <= asyncIn;
			syncOut    <= firstStage;
		end
	end
endmodule : interlock_sync

/* File: dv/dio_asserts.sv */
// Checker for the digital output port with interlock
`timescale 1ns/1ps
module dio_asserts (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        clkEn,
	input wire logic [3:0]  regAddr,
	input wire logic [31:0] regWriteData,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [31:0] regReadData,
	input wire logic        outputOnKey,
	input wire logic        outputOffKey,
	input wire logic        interlockIn,
	input wire logic [3:0]  portLines,
	input wire logic        mainOutputOn,
	input wire logic        interlockTripped
);
	logic [1:0] syn;
	logic       en;
	wire        ctl    = regWrite && regAddr == dio_pkg::CONTROL_ADDR;
	wire        onReq  = outputOnKey || (ctl && regWriteData[1]);
	wire        offReq = outputOffKey || (ctl && regWriteData[2]);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			syn <= 2'h3;
			en  <= 1'b0;
		end else if (clkEn) begin
			syn <= {syn[0], interlockIn};
			if (ctl)
				en <= regWriteData[0];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_PORT_WRITE: assert property (clkEn && regWrite && regAddr == dio_pkg::PORT_VALUE_ADDR |=>
		portLines == $past(regWriteData[3:0])) else $error("port lines wrong");
	AST_PORT_HOLD: assert property (!(regWrite && regAddr == dio_pkg::PORT_VALUE_ADDR) |=>
		$stable(portLines)) else $error("port lines moved");
	AST_READ_IDLE: assert property (!regRead |=> regReadData == '0) else $error("read data");
	AST_REFUSE: assert property (en && syn[1] |=> !mainOutputOn) else $error("output on");
	AST_TRIP: assert property (en && syn[1] && mainOutputOn |=> interlockTripped) else $error("no trip");
	AST_NO_RESTORE: assert property (!mainOutputOn && !onReq |=> !mainOutputOn) else $error("restored");
	AST_GRANT: assert property (onReq && !offReq && !(en && syn[1]) |=>
		mainOutputOn && !interlockTripped) else $error("on refused");
	AST_OFF: assert property (offReq |=> !mainOutputOn) else $error("off ignored");
endmodule : dio_asserts
bind digital_out_port_with_interlock dio_asserts chk_u (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
	.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
	.regReadData(regReadData), .outputOnKey(outputOnKey), .outputOffKey(outputOffKey), .interlockIn(interlockIn),
	.portLines(portLines), .mainOutputOn(mainOutputOn), .interlockTripped(interlockTripped));

/* File: dv/fixture_model.sv */
// Fixture lid switch driving the interlock pin
`timescale 1ns/1ps
module fixture_model (
	input wire logic lidClosed,
	output logic     interlockIn
);
	// Closed switch grounds the pin, pull-up otherwise
	assign interlockIn = lidClosed ? 1'b0 : 1'b1;
endmodule : fixture_model

/* File: dv/testbench.sv */
// Testbench for the digital output port with interlock
`timescale 1ns/1ps
module testbench;
	logic        clk_sys, rst, clkEn, regWrite, regRead, outputOnKey, outputOffKey, lidClosed, interlockIn;
	logic [3:0]  regAddr, portLines;
	logic [31:0] regWriteData, regReadData;
	logic        mainOutputOn, interlockTripped;
	int          error_cnt = 0;
	int          total_checks = 0;
	digital_out_port_with_interlock dut_u (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
		.outputOnKey(outputOnKey), .outputOffKey(outputOffKey), .interlockIn(interlockIn),
		.portLines(portLines), .mainOutputOn(mainOutputOn), .interlockTripped(interlockTripped));
	fixture_model fix_u (.lidClosed(lidClosed), .interlockIn(interlockIn));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 cmp(regReadData, exp);
	endtask : rd
	task automatic key(input logic on);
		@(posedge clk_sys);
		outputOnKey <= on;
		outputOffKey <= !on;
		@(posedge clk_sys);
		outputOnKey <= 1'b0;
		outputOffKey <= 1'b0;
		#1;
	endtask : key
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		#100000 error_cnt++;
		report_and_stop();
	end
	initial begin
		{rst, regWrite, regRead, outputOnKey, outputOffKey, lidClosed} = 6'h20;
		clkEn = 1'b1;
		regAddr = 4'h0;
		regWriteData = 32'h0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		#1 cmp(portLines, 32'h0);
		for (int v = 0; v < 16; v++) begin
			wr(dio_pkg::PORT_VALUE_ADDR, v);
			cmp(portLines, v);
		end
		rd(dio_pkg::PORT_VALUE_ADDR, 32'hf);
		rd(4'hc, 32'h0);
		// Write while frozen must not land
		@(posedge clk_sys);
		clkEn <= 1'b0;
		wr(dio_pkg::PORT_VALUE_ADDR, 32'h3);
		cmp(portLines, 32'hf);
		@(posedge clk_sys);
		clkEn <= 1'b1;
		$display("port test done");
		key(1'b1);
		cmp(mainOutputOn, 32'h1);
		key(1'b0);
		cmp(mainOutputOn, 32'h0);
		wr(dio_pkg::CONTROL_ADDR, 32'h1);
		wr(dio_pkg::CONTROL_ADDR, 32'h3);
		cmp(mainOutputOn, 32'h0);
		@(posedge clk_sys);
		lidClosed <= 1'b1;
		repeat (3) @(posedge clk_sys);
		wr(dio_pkg::CONTROL_ADDR, 32'h3);
		cmp(mainOutputOn, 32'h1);
		@(posedge clk_sys);
		lidClosed <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 cmp({interlockTripped, mainOutputOn}, 32'h2);
		@(posedge clk_sys);
		lidClosed <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1 rd(dio_pkg::STATUS_ADDR, 32'hc);
		key(1'b1);
		cmp({interlockTripped, mainOutputOn}, 32'h1);
		rd(dio_pkg::STATUS_ADDR, 32'h9);
		rd(dio_pkg::CONTROL_ADDR, 32'h1);
		$display("interlock test done");
		// Mid-run reset with port set, interlock on and output on
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		#1 cmp({interlockTripped, mainOutputOn, portLines}, 32'h0);
		rd(dio_pkg::CONTROL_ADDR, 32'h0);
		key(1'b1);
		cmp(mainOutputOn, 32'h1);
		wr(dio_pkg::CONTROL_ADDR, 32'h4);
		cmp(mainOutputOn, 32'h0);
		$display("reset test done");
		report_and_stop();
	end
endmodule : testbench
